// ### devctl_consts.vh
/*
 * constants for the mac device control register block: offsets, field
 * positions, reset values and timing counts.
 * assumes a 125 MHz register clock.
 */
`ifndef DEVCTL_CONSTS_VH
`define DEVCTL_CONSTS_VH

// =====================================================================
// register map
`define DEVICE_CONTROL_OFS   12'h000
`define DEVCTL_STATUS_OFS    12'h008

// =====================================================================
// field positions of device_control
`define DUPLEX_SELECT_BIT     0
`define MASTER_GATE_BIT       2
`define SPEED_LO_BIT          8
`define SPEED_HI_BIT          9
`define SPEED_FORCE_BIT       11
`define DUPLEX_FORCE_BIT      12
`define PIN_OVERRIDE_BIT      16
`define PIN_VALUE_BIT         17
`define SPARE_BIT             19
`define PHY_POWERDOWN_BIT     24
`define HOST_TO_MGMT_IRQ_BIT  25
`define HOST_SOFT_RESET_BIT   26
`define RX_PAUSE_ENABLE_BIT   27
`define TX_PAUSE_ENABLE_BIT   28
`define VLAN_TAG_ENABLE_BIT   30
`define ATTACHED_PHY_RST_BIT  31

// writable bits: 0,2,9:8,11,12,16,17,19,24..28,30,31
`define DEVCTL_RW_MASK        32'hDF0B1B05
`define DEVCTL_RESET_VALUE    32'h00000201

// =====================================================================
// speed codes and nvm signature
`define SPEED_10              2'h0
`define SPEED_100             2'h1
`define SPEED_1000            2'h2
`define NVM_SIG_VALID         2'h1

// =====================================================================
// timing
`define CLK_PERIOD_NS         8
`define SOFT_RESET_TIME_NS    1000
`define SOFT_RESET_CYCLES     ((`SOFT_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PHY_RESET_TIME_NS     1000
`define PHY_RESET_CYCLES      ((`PHY_RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### device_control.v
/*
 * device control register of an ethernet mac, reached over apb.
 * holds the control word, the reset sequencer, master gating, speed and
 * duplex resolution and the phy power pin selection.
 * assumes pclk at 125 MHz, presetn asynchronous active low, all other
 * inputs synchronous to pclk; nvm load strobe comes from the loader.
 * assumes zero wait states on apb; the status word sits at 0x008 and is
 * read-only, so writes to it are dropped without an error.
 * assumes software leaves the block alone for the soft reset window;
 * writes inside it are accepted but lost when the window ends.
 * a soft reset also returns status, speed and duplex to reset values.
 * assumes the buffer split register is written only by its owner port.
 */
// Function
// - bit 0 selects duplex when forced; resets to 1, loaded from nvm word 13h.
// - bit 2 blocks new master requests; master-enable status clears when none pending.
// - speed field bits 9:8 resets to 10b; 00=10M, 01=100M, 10=1000M.
// - speed field ignored while automatic speed detection is enabled and neither bit 11 nor speed bypass is set.
// - bit 11 forces speed from field; speed bypass has precedence; nvm loaded.
// - bit 12 forces duplex from bit 0; else sample phy duplex on link rise.
// - bit 16 set drives phy power pin with bit 17; else internal logic.
// - bit 24 with powerdown gate enable powers phy down through the pin.
// - writing 1 to bit 25 pulses interrupt to management engine; self-clears.
// - writing 1 to bit 26 starts host data path reset; clears when done.
// - bit 27 enables acting on pause frames; loaded by auto-negotiation.
// - bit 28 enables sending pause frames; loaded by auto-negotiation.
// - bit 30 enables vlan tag insertion on transmit and strip on receive.
// - bit 31 resets phy then self-clears; only when firmware permit set.
// - soft reset restores most state but keeps buffer split register.
// - nvm fields update only when init word signature equals 01b.
`timescale 1ns/1ps
`include "devctl_consts.vh"

module device_control #(
   parameter SOFT_RESET_CYCLES = `SOFT_RESET_CYCLES,
   parameter PHY_RESET_CYCLES  = `PHY_RESET_CYCLES
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   input  wire        nvm_load,
   input  wire [1:0]  nvm_signature,
   input  wire        nvm_duplex_select,
   input  wire        nvm_speed_force,
   input  wire        auto_speed_detect,
   input  wire [1:0]  detected_speed,
   input  wire        speed_bypass,
   input  wire        phy_duplex_indication,
   input  wire        phy_link,
   input  wire        powerdown_gate_enable,
   input  wire        internal_phy_pc,
   input  wire        phy_reset_permit,
   input  wire        autoneg_enable,
   input  wire        autoneg_done,
   input  wire        autoneg_rx_pause,
   input  wire        autoneg_tx_pause,
   input  wire        master_req_in,
   input  wire        master_pending,
   input  wire [15:0] buffer_split_wdata,
   input  wire        buffer_split_we,
   output wire        master_req_out,
   output reg         master_enable_status,
   output reg         mac_full_duplex,
   output reg  [1:0]  mac_speed,
   output wire        phy_power_ctrl_pin,
   output reg         host_to_mgmt_irq,
   output wire        host_soft_reset_active,
   output wire        attached_phy_reset,
   output wire        rx_pause_enable,
   output wire        tx_pause_enable,
   output wire        vlan_tag_enable,
   output reg  [15:0] buffer_split_reg
);

   // ==================================================================
   // apb decode
   localparam [31:0] RW_MASK  = `DEVCTL_RW_MASK;
   localparam [31:0] RST_VAL  = `DEVCTL_RESET_VALUE;
   localparam [11:0] CTRL_OFS = `DEVICE_CONTROL_OFS;
   localparam [11:0] STAT_OFS = `DEVCTL_STATUS_OFS;

   // one-hot reset sequencer states
   localparam [2:0] ST_IDLE  = 3'h1;
   localparam [2:0] ST_HOST_SOFT_RESET = 3'h2;
   localparam [2:0] ST_PHYRST = 3'h4;

   // window lengths, cut on purpose to the width of the down counter
   localparam [31:0] SRST_LEN = SOFT_RESET_CYCLES;
   localparam [31:0] PRST_LEN = PHY_RESET_CYCLES;

   // word decode: the two low address bits are ignored
   function hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         hit = (a[11:2] == ofs[11:2]);
      end
   endfunction

   wire access   = psel & penable;
   wire wr_ctrl  = access & pwrite & hit(paddr, CTRL_OFS);
   wire rd_known = hit(paddr, CTRL_OFS) | hit(paddr, STAT_OFS);

   // zero wait states; only unmapped words raise an error
   assign pready  = 1'b1;
   assign pslverr = access & ~rd_known;

   reg  [31:0] ctrl_reg;
   reg  [31:0] ctrl_next;
   reg  [2:0]  state_reg;
   reg  [2:0]  state_next;
   reg  [15:0] count_reg;
   reg  [15:0] count_next;
   reg         phy_rst_reg;
   reg         phy_rst_next;
   reg         link_d_reg;

   // soft reset acts as a synchronous clear of the register state
   wire soft_rst = state_reg[1] & (count_reg == 16'h0000);

   // ==================================================================
   // control register update
   always @* begin
      ctrl_next = ctrl_reg;
      // bits 25/26/31 never store a value; they are tracked as events
      ctrl_next[`HOST_TO_MGMT_IRQ_BIT] = 1'b0;
      if (wr_ctrl)
         ctrl_next = pwdata & RW_MASK;
      if (nvm_load && nvm_signature == `NVM_SIG_VALID) begin
         ctrl_next[`DUPLEX_SELECT_BIT] = nvm_duplex_select;
         ctrl_next[`SPEED_FORCE_BIT]   = nvm_speed_force;
      end
      if (autoneg_enable && autoneg_done) begin
         ctrl_next[`RX_PAUSE_ENABLE_BIT] = autoneg_rx_pause;
         ctrl_next[`TX_PAUSE_ENABLE_BIT] = autoneg_tx_pause;
      end
      // self-clearing bits 26 and 31 report the sequencer, not the write; bit 25 reads 0
      ctrl_next[`HOST_TO_MGMT_IRQ_BIT] = 1'b0;
      ctrl_next[`HOST_SOFT_RESET_BIT]  = 1'b0;
      ctrl_next[`ATTACHED_PHY_RST_BIT] = 1'b0;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_reg <= `DEVCTL_RESET_VALUE;
      else if (soft_rst)
         ctrl_reg <= RST_VAL;
      else
         ctrl_reg <= ctrl_next;
   end

   // ==================================================================
   // interrupt pulse toward management engine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         host_to_mgmt_irq <= 1'b0;
      else
         host_to_mgmt_irq <= wr_ctrl & pwdata[`HOST_TO_MGMT_IRQ_BIT];
   end

   // ==================================================================
   // soft reset and phy reset sequencer
   // a write inside the window is accepted but lost when the window ends
   wire sw_req  = wr_ctrl & pwdata[`HOST_SOFT_RESET_BIT];
   // without the permit the phy reset request is dropped here
   wire phy_req = wr_ctrl & pwdata[`ATTACHED_PHY_RST_BIT] & phy_reset_permit;

   always @* begin
      state_next   = state_reg;
      count_next   = count_reg;
      phy_rst_next = phy_rst_reg;
      case (state_reg)
         ST_IDLE: begin
            if (sw_req) begin
               state_next   = ST_HOST_SOFT_RESET;
               count_next   = SRST_LEN[15:0] - 16'h0001;
               phy_rst_next = phy_req;
            end else if (phy_req) begin
               state_next   = ST_PHYRST;
               count_next   = PRST_LEN[15:0] - 16'h0001;
               phy_rst_next = 1'b1;
            end
         end
         ST_HOST_SOFT_RESET, ST_PHYRST: begin
            if (count_reg == 16'h0000) begin
               state_next   = ST_IDLE;
               phy_rst_next = 1'b0;
            end else begin
               count_next = count_reg - 16'h0001;
            end
         end
         default: begin
            state_next   = ST_IDLE;
            phy_rst_next = 1'b0;
         end
      endcase
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= ST_IDLE;
         count_reg   <= 16'h0000;
         phy_rst_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         count_reg   <= count_next;
         phy_rst_reg <= phy_rst_next;
      end
   end

   assign host_soft_reset_active = state_reg[1];
   assign attached_phy_reset     = phy_rst_reg;

   // ==================================================================
   // buffer split register survives soft reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         buffer_split_reg <= 16'h0000;
      else if (buffer_split_we)
         buffer_split_reg <= buffer_split_wdata;
   end

   // ==================================================================
   // master gating
   wire gate = ctrl_reg[`MASTER_GATE_BIT];
   assign master_req_out = master_req_in & ~gate;

   // status drops only once the gate is up and nothing is left in flight
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         master_enable_status <= 1'b1;
      else if (soft_rst)
         master_enable_status <= 1'b1;
      else
         master_enable_status <= ~(gate & ~master_pending);
   end

   // ==================================================================
   // speed and duplex resolution
   // force and bypass both take bits 9:8; otherwise auto detect wins when enabled, else bits 9:8 again
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_d_reg      <= 1'b0;
         mac_full_duplex <= 1'b1;
         mac_speed       <= `SPEED_1000;
      end else if (soft_rst) begin
         link_d_reg      <= phy_link;
         mac_full_duplex <= 1'b1;
         mac_speed       <= `SPEED_1000;
      end else begin
         link_d_reg <= phy_link;
         if (ctrl_reg[`DUPLEX_FORCE_BIT])
            mac_full_duplex <= ctrl_reg[`DUPLEX_SELECT_BIT];
         else if (phy_link && !link_d_reg)
            mac_full_duplex <= phy_duplex_indication;
         if (speed_bypass || ctrl_reg[`SPEED_FORCE_BIT])
            mac_speed <= ctrl_reg[`SPEED_HI_BIT:`SPEED_LO_BIT];
         else if (auto_speed_detect)
            mac_speed <= detected_speed;
         else
            mac_speed <= ctrl_reg[`SPEED_HI_BIT:`SPEED_LO_BIT];
      end
   end

   // ==================================================================
   // phy power pin: override, then powerdown, then internal logic
   assign phy_power_ctrl_pin =
      ctrl_reg[`PIN_OVERRIDE_BIT] ? ctrl_reg[`PIN_VALUE_BIT] :
      (ctrl_reg[`PHY_POWERDOWN_BIT] & powerdown_gate_enable) ? 1'b1 :
      internal_phy_pc;

   assign rx_pause_enable = ctrl_reg[`RX_PAUSE_ENABLE_BIT];
   assign tx_pause_enable = ctrl_reg[`TX_PAUSE_ENABLE_BIT];
   assign vlan_tag_enable = ctrl_reg[`VLAN_TAG_ENABLE_BIT];

   // ==================================================================
   // read path
   wire [31:0] ctrl_view = ctrl_reg
      | (state_reg[1] ? 32'h04000000 : 32'h00000000)
      | (phy_rst_reg ? 32'h80000000 : 32'h00000000);
   wire [31:0] stat_view = {27'h0000000, master_enable_status, mac_speed,
                            mac_full_duplex, attached_phy_reset};

   // read data is taken in the setup cycle so it stands through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable && !pwrite)
         prdata <= hit(paddr, CTRL_OFS) ? ctrl_view :
                   hit(paddr, STAT_OFS) ? stat_view : 32'h00000000;
   end

endmodule

// ### device_control_asserts.sv
/* port-level checker for device_control, holding a shadow of the control bits.
   assumes a bind onto device_control; one clock pclk, reset presetn. */
`timescale 1ns/1ps
`include "devctl_consts.vh"
module device_control_asserts (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        powerdown_gate_enable,
   input wire        internal_phy_pc,
   input wire        phy_reset_permit,
   input wire        master_req_in,
   input wire        master_pending,
   input wire        master_req_out,
   input wire        master_enable_status,
   input wire        phy_power_ctrl_pin,
   input wire        host_to_mgmt_irq,
   input wire        host_soft_reset_active,
   input wire        attached_phy_reset,
   input wire        vlan_tag_enable
);
   // =====================================================================
   // shadow of written bits, parked at reset value around a soft reset
   logic [31:0] ctl_q;
   logic        srq;
   wire         quiet = host_soft_reset_active | srq;
   wire         wr0   = psel & penable & pwrite & (paddr == `DEVICE_CONTROL_OFS);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= `DEVCTL_RESET_VALUE;
         srq   <= 1'b0;
      end else begin
         srq <= host_soft_reset_active;
         if (quiet)
            ctl_q <= `DEVCTL_RESET_VALUE;
         else if (wr0)
            ctl_q <= pwdata;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====================================================================
   // properties
   property p_req_gate;
      !quiet |-> master_req_out == (master_req_in & ~ctl_q[`MASTER_GATE_BIT]);
   endproperty
   a_req_gate: assert property (p_req_gate) else $error("request not gated");
   property p_mes_low;
      !master_enable_status && !quiet |-> $past(ctl_q[2] && !master_pending);
   endproperty
   a_mes_low: assert property (p_mes_low) else $error("status cleared early");
   property p_pin_ovr;
      !quiet && ctl_q[16] |-> phy_power_ctrl_pin == ctl_q[17];
   endproperty
   a_pin_ovr: assert property (p_pin_ovr) else $error("pin not overridden");
   property p_pin_pd;
      !quiet && !ctl_q[16] && ctl_q[24] && powerdown_gate_enable |-> phy_power_ctrl_pin;
   endproperty
   a_pin_pd: assert property (p_pin_pd) else $error("pin not powering down");
   property p_pin_int;
      !quiet && !ctl_q[16] && !ctl_q[24] |-> phy_power_ctrl_pin == internal_phy_pc;
   endproperty
   a_pin_int: assert property (p_pin_int) else $error("pin not internal");
   property p_vlan;
      !quiet |-> vlan_tag_enable == ctl_q[30];
   endproperty
   a_vlan: assert property (p_vlan) else $error("vlan enable wrong");
   property p_irq;
      wr0 && pwdata[25] |=> host_to_mgmt_irq ##1 !host_to_mgmt_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq not one pulse");
   property p_srst;
      wr0 && pwdata[26] && !quiet |=> host_soft_reset_active [*4];
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset not started");
   property p_prst;
      wr0 && pwdata[31] && !phy_reset_permit && !attached_phy_reset |=> !attached_phy_reset;
   endproperty
   a_prst: assert property (p_prst) else $error("phy reset not gated");
   property p_rsv;
      psel && penable && !pwrite && paddr == 12'h000 |-> (prdata & ~`DEVCTL_RW_MASK) == 32'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits nonzero");
   c_srst: cover property (wr0 && pwdata[26]);
   c_irq: cover property (host_to_mgmt_irq);
   c_mes: cover property (!master_enable_status);
endmodule
bind device_control device_control_asserts device_control_asserts_inst (.*);

// ### mac_device_control_register_test.sv
/* self-checking bench for device_control over apb.
   assumes devctl_consts.vh, phy_model and the bound checker. */
`timescale 1ns/1ps
`include "devctl_consts.vh"
module mac_device_control_register_test;
   localparam int SRC = 16;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic        nvm_load = 0, nvm_duplex_select = 0, nvm_speed_force = 0;
   logic [1:0]  nvm_signature = 0, detected_speed = 0;
   logic        auto_speed_detect = 0, speed_bypass = 0, powerdown_gate_enable = 0;
   logic        internal_phy_pc = 0, phy_reset_permit = 0, autoneg_enable = 0;
   logic        autoneg_done = 0, autoneg_rx_pause = 0, autoneg_tx_pause = 0;
   logic        master_req_in = 0, master_pending = 0, buffer_split_we = 0;
   logic [15:0] buffer_split_wdata = 0;
   logic        link_req = 0, fdx_req = 0, last_err;
   wire         pready, pslverr, master_req_out, master_enable_status, mac_full_duplex;
   wire         phy_power_ctrl_pin, host_to_mgmt_irq, host_soft_reset_active;
   wire         attached_phy_reset, rx_pause_enable, tx_pause_enable, vlan_tag_enable;
   wire         phy_link, phy_duplex_indication;
   wire [31:0]  prdata;
   wire [1:0]   mac_speed;
   wire [15:0]  buffer_split_reg;
   int          errors = 0, checks = 0, n;
   device_control #(.SOFT_RESET_CYCLES(SRC), .PHY_RESET_CYCLES(4)) device_control_inst (.*);
   phy_model phy_model_inst (.pclk(pclk), .link_req(link_req), .fdx_req(fdx_req),
      .attached_phy_reset(attached_phy_reset), .phy_link(phy_link),
      .phy_duplex_indication(phy_duplex_indication));
   always #4 pclk = ~pclk;
   // =====================================================================
   // shared tasks
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin
         errors++;
         report_and_stop();
      end
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask
   // =====================================================================
   // scenarios
   task automatic t_fields;
      apb(0, 0, 0);
      chk("reset ctrl", rd, `DEVCTL_RESET_VALUE);
      chk("reset speed", mac_speed, `SPEED_1000);
      master_req_in <= 1;
      master_pending <= 1;
      apb(1, 0, 32'h590B1B05);
      apb(0, 0, 0);
      chk("ctrl rw", rd, 32'h590B1B05);
      chk("enables", {vlan_tag_enable, tx_pause_enable, rx_pause_enable}, 3'b111);
      chk("pin ovr", phy_power_ctrl_pin, 1'b1);
      chk("req gated", master_req_out, 1'b0);
      chk("mes held", master_enable_status, 1'b1);
      master_pending <= 0;
      cyc(3);
      chk("mes clear", master_enable_status, 1'b0);
      @(posedge pclk);
      powerdown_gate_enable <= 1;
      apb(1, 0, 32'h01001000);
      cyc(2);
      chk("duplex forced", mac_full_duplex, 1'b0);
      chk("pin pd", phy_power_ctrl_pin, 1'b1);
      @(posedge pclk);
      powerdown_gate_enable <= 0;
      cyc(1);
      chk("pin int", phy_power_ctrl_pin, internal_phy_pc);
      $display("done fields");
   endtask
   task automatic t_speed;
      for (int c = 0; c < 3; c++) begin
         apb(1, 0, 32'h800 | (c << 8));
         cyc(2);
         chk("forced speed", mac_speed, c);
      end
      @(posedge pclk);
      auto_speed_detect <= 1;
      detected_speed <= `SPEED_100;
      apb(1, 0, 0);
      cyc(2);
      chk("auto speed", mac_speed, `SPEED_100);
      @(posedge pclk);
      speed_bypass <= 1;
      cyc(2);
      chk("bypass speed", mac_speed, `SPEED_10);
      @(posedge pclk);
      speed_bypass <= 0;
      auto_speed_detect <= 0;
      fdx_req <= 1;
      link_req <= 1;
      cyc(4);
      chk("link duplex", mac_full_duplex, 1'b1);
      @(posedge pclk);
      fdx_req <= 0;
      cyc(4);
      chk("duplex held", mac_full_duplex, 1'b1);
      $display("done speed");
   endtask
   task automatic t_nvm_irq;
      apb(1, 0, 32'h1);
      nvm_speed_force <= 1;
      nvm_signature <= 2'h2;
      nvm_load <= 1;
      @(posedge pclk);
      nvm_load <= 0;
      apb(0, 0, 0);
      chk("nvm bad sig", rd, 32'h1);
      nvm_signature <= `NVM_SIG_VALID;
      nvm_load <= 1;
      @(posedge pclk);
      nvm_load <= 0;
      apb(0, 0, 0);
      chk("nvm load", rd, 32'h800);
      autoneg_enable <= 1;
      autoneg_rx_pause <= 1;
      autoneg_done <= 1;
      @(posedge pclk);
      autoneg_done <= 0;
      cyc(1);
      chk("autoneg pause", {tx_pause_enable, rx_pause_enable}, 2'b01);
      apb(1, 0, 32'h02000000);
      #1;
      chk("irq high", host_to_mgmt_irq, 1'b1);
      cyc(1);
      chk("irq low", host_to_mgmt_irq, 1'b0);
      apb(1, 12'h010, 32'hFFFFFFFF);
      chk("slverr", last_err, 1'b1);
      apb(0, 0, 0);
      chk("no mirror", rd, 32'h0);
      $display("done nvm irq");
   endtask
   task automatic t_resets;
      buffer_split_wdata <= 16'hA5C3;
      buffer_split_we <= 1;
      apb(1, 0, 32'h80000000);
      buffer_split_we <= 0;
      cyc(2);
      chk("no permit", attached_phy_reset, 1'b0);
      @(posedge pclk);
      phy_reset_permit <= 1;
      apb(1, 0, 32'h84080000);
      n = 0;
      cyc(1);
      chk("phy reset", attached_phy_reset, 1'b1);
      while (host_soft_reset_active === 1'b1 && n < 500) begin
         cyc(1);
         n++;
      end
      chk("window", n + 1, SRC);
      cyc(`SOFT_RESET_CYCLES);
      apb(0, 0, 0);
      chk("after host_soft_reset", rd, `DEVCTL_RESET_VALUE);
      chk("split kept", buffer_split_reg, 16'hA5C3);
      $display("done resets");
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      #400000;
      errors++;
      report_and_stop();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1;
      t_fields();
      t_speed();
      t_nvm_irq();
      t_resets();
      report_and_stop();
   end
endmodule

// ### phy_model.sv
/* behavioural attached phy: link and duplex indication, link held down in reset.
   assumes requests from the bench, synchronous to pclk. */
`timescale 1ns/1ps
module phy_model (
   input  wire  pclk,
   input  wire  link_req,
   input  wire  fdx_req,
   input  wire  attached_phy_reset,
   output logic phy_link = 1'b0,
   output logic phy_duplex_indication = 1'b0
);
   // duplex is meaningless without link, so it wanders then
   always @(posedge pclk) begin
      phy_link <= link_req & ~attached_phy_reset;
      phy_duplex_indication <= link_req ? fdx_req : ~phy_duplex_indication;
   end
endmodule
